// *** rtl/scr_channel_config.sv ***
/*
  Configuration registers of a two-channel serial controller: interrupt/wait
  control, interrupt vector (channel B only), receiver control, framing/mode
  and station address, reached by a pointer in the command register.
  Assumes the host write strobe and the receiver event inputs are on core_clk;
  modem pins are asynchronous and are synchronised here.
*/
// Functional notes
// - transmit interrupt on buffer becoming empty when transmit interrupt enabled
// - channel B status-affects-vector replaces vector bits 1..3, else vector unchanged
// - receive interrupt mode: off, first char, every char, every char ignoring parity
// - bit5 follows receive or transmit buffer; bit6 picks ready or wait
// - disabled: wait floats, ready drives high
// - wait on transmit: low while full and port accessed, else floats
// - ready on transmit: high while full, low while empty
// - wait on receive: low while empty and port accessed, else floats
// - ready on receive: low while full, high while empty
// - modified vector: bit3 channel A is 1, bits 2:1 condition code
// - receive enable starts reception; host sets it last
// - sync load inhibit in sync modes discards sync characters
// - SDLC address search accepts only station or global address frames
// - receive CRC enable includes characters moved into the receive buffer
// - enter-hunt starts hunt; cleared when synchronisation is found
// - auto enable gates transmitter by clear-to-send, receiver by carrier detect
// - character length code 00=5, 01=7, 10=6, 11=8 bits
// - parity bit stored above data for lengths below 8, dropped at 8
// - parity sense 1 even, 0 odd, for generation and checking
// - stop code 00 sync, 01 one, 10 one and half, 11 two
// - sync mode 00 8-bit, 01 16-bit, 10 SDLC, 11 external
// - pointer selects next byte's register, then returns to command register
`timescale 1ns/1ns
module scr_channel_config (
  input wire logic core_clk,                   // system clock
  input wire logic reset,                      // asynchronous, active high
  input wire logic host_wr,                    // host byte write strobe
  input wire logic host_chan,                  // 0 channel A, 1 channel B
  input wire logic [7:0] host_data,            // host write byte
  input wire logic [1:0] cts_n,                // clear-to-send pins, async
  input wire logic [1:0] carrier_detect_in,    // carrier detect pins (low active), async
  input wire logic [1:0] tx_en_req,            // transmitter enable from transmit control
  input wire logic [1:0] tx_empty,             // transmit buffer empty
  input wire logic [1:0] rx_full,              // receive buffer full
  input wire logic [1:0] port_sel,             // data port being accessed
  input wire logic [1:0] rx_char_done,         // character assembled in shift register
  input wire logic [17:0] rx_raw,              // per channel 9 bits, data LSB first, parity at length
  input wire logic [1:0] rx_is_sync,           // assembled character is sync or idle sync
  input wire logic [1:0] rx_is_addr,           // assembled character is SDLC address field
  input wire logic [1:0] rx_overrun,           // overrun with this character
  input wire logic [1:0] rx_framing_err,       // framing error with this character
  input wire logic [1:0] rx_eof,               // end of frame with this character
  input wire logic [1:0] sync_found,           // synchronisation established
  input wire logic vec_chan_a,                 // interrupting channel is A
  input wire scr_pkg::scr_cond_e vec_cond,     // interrupting condition
  output logic [7:0] vector_out,               // vector supplied on acknowledge
  output logic [1:0] tx_irq,                   // transmit interrupt pulse
  output logic [1:0] rx_irq,                   // receive interrupt pulse
  output logic [1:0] rx_store,                 // character loaded into receive buffer
  output logic [15:0] rx_byte,                 // stored byte per channel
  output logic [1:0] rx_parity_err,            // parity error with stored byte
  output logic [1:0] crc_update,               // include stored byte in CRC
  output logic [1:0] hunt,                     // receiver in hunt phase
  output logic [1:0] tx_enable,                // effective transmitter enable
  output logic [1:0] rx_enable,                // effective receiver enable
  output logic [7:0] char_bits,                // 4 bits per channel: bits per character
  output logic [1:0] parity_en,                // parity enabled
  output logic [1:0] parity_even,              // parity sense
  output logic [3:0] stop_code,                // 2 bits per channel
  output logic [3:0] sync_mode,                // 2 bits per channel
  output logic [1:0] wait_ready_o,             // wait/ready pin level
  output logic [1:0] wait_ready_oe             // wait/ready pin driven
);
  import scr_pkg::*;

  logic [2:0] ptr_q [SCR_CHANNELS];
  logic [7:0] iwc_q [SCR_CHANNELS];
  logic [7:0] rxc_q [SCR_CHANNELS];
  logic [7:0] frm_q [SCR_CHANNELS];
  logic [7:0] sta_q [SCR_CHANNELS];
  logic [7:0] vec_q;
  logic [1:0] cts_m_q, cts_s_q, dcd_m_q, dcd_s_q;
  logic [1:0] tx_empty_q, first_armed_q, frame_ok_q, hunt_q;
  logic [1:0] wr_ch, chan_rst, accept, special, par_err_c;
  logic [7:0] byte_c [SCR_CHANNELS];
  logic [3:0] len_c [SCR_CHANNELS];

  // modem pins come from outside the clock domain
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cts_m_q <= 2'h3;
      cts_s_q <= 2'h3;
      dcd_m_q <= 2'h3;
      dcd_s_q <= 2'h3;
    end else begin
      cts_m_q <= cts_n;
      cts_s_q <= cts_m_q;
      dcd_m_q <= carrier_detect_in;
      dcd_s_q <= dcd_m_q;
    end
  end

  always_comb begin
    for (int c = 0; c < SCR_CHANNELS; c++) begin
      wr_ch[c] = host_wr && (host_chan == c[0]);
      chan_rst[c] = wr_ch[c] && ptr_q[c] == SCR_PTR_CMD && host_data[SCR_CMD_LSB +: 3] == SCR_CMD_CHAN_RESET;
    end
  end

  // pointer and register writes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int c = 0; c < SCR_CHANNELS; c++) begin
        ptr_q[c] <= SCR_PTR_CMD;
        iwc_q[c] <= SCR_REG_RESET;
        rxc_q[c] <= SCR_REG_RESET;
        frm_q[c] <= SCR_REG_RESET;
        sta_q[c] <= SCR_REG_RESET;
      end
      vec_q <= SCR_REG_RESET;
    end else begin
      for (int c = 0; c < SCR_CHANNELS; c++) begin
        if (chan_rst[c]) begin
          ptr_q[c] <= SCR_PTR_CMD;
          iwc_q[c] <= SCR_REG_RESET;
          rxc_q[c] <= SCR_REG_RESET;
          frm_q[c] <= SCR_REG_RESET;
          sta_q[c] <= SCR_REG_RESET;
        end else if (wr_ch[c]) begin
          if (ptr_q[c] == SCR_PTR_CMD) begin
            ptr_q[c] <= host_data[2:0];
          end else begin
            ptr_q[c] <= SCR_PTR_CMD;
            case (ptr_q[c])
              SCR_PTR_IWC: iwc_q[c] <= host_data;
              SCR_PTR_RXC: rxc_q[c] <= host_data;
              SCR_PTR_FRM: frm_q[c] <= host_data;
              SCR_PTR_STA: sta_q[c] <= host_data;
              default: ;
            endcase
          end
        end
      end
      // vector storage lives in channel B only; a write via A is dropped
      if (wr_ch[SCR_CH_B] && ptr_q[SCR_CH_B] == SCR_PTR_VEC) begin
        vec_q <= host_data;
      end
    end
  end

  // receive character decode, length and parity
  always_comb begin
    for (int c = 0; c < SCR_CHANNELS; c++) begin
      logic [8:0] raw;
      logic [8:0] keep;
      raw = rx_raw[c*9 +: 9];
      keep = 9'h000;
      case (rxc_q[c][SCR_RXC_LEN_LSB +: 2])
        2'h0: len_c[c] = 4'h5;
        2'h1: len_c[c] = 4'h7;
        2'h2: len_c[c] = 4'h6;
        default: len_c[c] = 4'h8;
      endcase
      keep = (9'h001 << (len_c[c] + 4'h1)) - 9'h001;
      par_err_c[c] = frm_q[c][SCR_FRM_PAR_EN] && ((^(raw & keep)) == frm_q[c][SCR_FRM_PAR_EVEN]);
      if (!frm_q[c][SCR_FRM_PAR_EN] || len_c[c] == 4'h8) begin
        keep = (9'h001 << len_c[c]) - 9'h001;
      end
      byte_c[c] = raw[7:0] & keep[7:0];
      accept[c] = rx_char_done[c] && rxc_q[c][SCR_RXC_EN] && rx_enable[c]
        && !(frm_q[c][SCR_FRM_STOP_LSB +: 2] == SCR_STOP_SYNC
             && rxc_q[c][SCR_RXC_SYNC_INH] && rx_is_sync[c])
        && (rx_is_addr[c] ? addr_ok(c, raw[7:0]) : frame_ok_q[c]);
      special[c] = rx_overrun[c] || rx_framing_err[c]
        || (par_err_c[c] && iwc_q[c][SCR_IWC_RXMODE_LSB +: 2] != SCR_RXI_ALL_NOPAR)
        || (rx_eof[c] && frm_q[c][SCR_FRM_SYNC_LSB +: 2] == SCR_SYNC_SDLC
            && frm_q[c][SCR_FRM_STOP_LSB +: 2] == SCR_STOP_SYNC);
    end
  end

  function automatic logic addr_ok(input int c, input logic [7:0] a);
    logic srch;
    srch = rxc_q[c][SCR_RXC_ADDR_SRCH] && frm_q[c][SCR_FRM_STOP_LSB +: 2] == SCR_STOP_SYNC
      && frm_q[c][SCR_FRM_SYNC_LSB +: 2] == SCR_SYNC_SDLC;
    return !srch || a == sta_q[c] || a == SCR_GLOBAL_ADDR;
  endfunction : addr_ok

  // frame address match and first-character arming
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      frame_ok_q <= 2'h3;
      first_armed_q <= 2'h3;
    end else begin
      for (int c = 0; c < SCR_CHANNELS; c++) begin
        if (rx_char_done[c] && rx_is_addr[c]) begin
          frame_ok_q[c] <= addr_ok(c, rx_raw[c*9 +: 8]);
        end
        // re-arm beats consumption so a re-arm in the same cycle is not lost
        if (chan_rst[c] || (wr_ch[c] && ptr_q[c] == SCR_PTR_CMD
            && host_data[SCR_CMD_LSB +: 3] == SCR_CMD_RX_REARM)) begin
          first_armed_q[c] <= 1'b1;
        end else if (accept[c]) begin
          first_armed_q[c] <= 1'b0;
        end
      end
    end
  end

  // interrupt pulses and stored character
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      // buffers come out of reset empty; a zero here would fake an empty edge
      tx_empty_q <= 2'h3;
      tx_irq <= 2'h0;
      rx_irq <= 2'h0;
      rx_store <= 2'h0;
      crc_update <= 2'h0;
      rx_parity_err <= 2'h0;
      rx_byte <= 16'h0000;
    end else begin
      tx_empty_q <= tx_empty;
      for (int c = 0; c < SCR_CHANNELS; c++) begin
        tx_irq[c] <= iwc_q[c][SCR_IWC_TX_IE] && tx_empty[c] && !tx_empty_q[c];
        case (scr_rxi_e'(iwc_q[c][SCR_IWC_RXMODE_LSB +: 2]))
          SCR_RXI_OFF: rx_irq[c] <= 1'b0;
          SCR_RXI_FIRST: rx_irq[c] <= accept[c] && (first_armed_q[c] || special[c]);
          SCR_RXI_ALL, SCR_RXI_ALL_NOPAR: rx_irq[c] <= accept[c];
          default: rx_irq[c] <= 1'b0;
        endcase
        rx_store[c] <= accept[c];
        crc_update[c] <= accept[c] && rxc_q[c][SCR_RXC_CRC_EN];
        if (accept[c]) begin
          rx_byte[c*8 +: 8] <= byte_c[c];
          rx_parity_err[c] <= par_err_c[c];
        end
      end
    end
  end

  // hunt phase: host entry beats the clear from the receiver
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hunt_q <= 2'h3;
    end else begin
      for (int c = 0; c < SCR_CHANNELS; c++) begin
        if (chan_rst[c]) begin
          hunt_q[c] <= 1'b1;
        end else if (wr_ch[c] && ptr_q[c] == SCR_PTR_RXC && host_data[SCR_RXC_HUNT]) begin
          hunt_q[c] <= 1'b1;
        end else if (sync_found[c]) begin
          hunt_q[c] <= 1'b0;
        end
      end
    end
  end

  // vector issued on acknowledge; the stored register is never altered
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      vector_out <= SCR_REG_RESET;
    end else if (iwc_q[SCR_CH_B][SCR_IWC_SAV]) begin
      vector_out <= {vec_q[7:4], vec_chan_a, vec_cond, vec_q[0]};
    end else begin
      vector_out <= vec_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < SCR_CHANNELS; g++) begin : g_ch
      assign tx_enable[g] = tx_en_req[g] && !(rxc_q[g][SCR_RXC_AUTO] && cts_s_q[g]);
      assign rx_enable[g] = rxc_q[g][SCR_RXC_EN] && !(rxc_q[g][SCR_RXC_AUTO] && dcd_s_q[g]);
      assign char_bits[g*4 +: 4] = len_c[g];
      assign parity_en[g] = frm_q[g][SCR_FRM_PAR_EN];
      assign parity_even[g] = frm_q[g][SCR_FRM_PAR_EVEN];
      assign stop_code[g*2 +: 2] = frm_q[g][SCR_FRM_STOP_LSB +: 2];
      assign sync_mode[g*2 +: 2] = frm_q[g][SCR_FRM_SYNC_LSB +: 2];
      assign hunt[g] = hunt_q[g];
      scr_wait_ready u_wr (
        .enable(iwc_q[g][SCR_IWC_WR_EN]),
        .ready_sel(iwc_q[g][SCR_IWC_WR_READY]),
        .follow_rx(iwc_q[g][SCR_IWC_WR_RX]),
        .tx_full(!tx_empty[g]),
        .rx_full(rx_full[g]),
        .port_sel(port_sel[g]),
        .pin_o(wait_ready_o[g]),
        .pin_oe(wait_ready_oe[g])
      );
    end
  endgenerate

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  tx_irq_edge_a: assert property ($rose(tx_empty[0]) && iwc_q[0][SCR_IWC_TX_IE] |=> tx_irq[0])
    else $error("transmit interrupt missing on empty");
  tx_irq_off_a: assert property (!iwc_q[1][SCR_IWC_TX_IE] |=> !tx_irq[1])
    else $error("transmit interrupt while disabled");
  vec_plain_a: assert property (!iwc_q[SCR_CH_B][SCR_IWC_SAV] |=> vector_out == $past(vec_q))
    else $error("vector altered without status-affects-vector");
  vec_mod_a: assert property (iwc_q[SCR_CH_B][SCR_IWC_SAV] |=>
    vector_out[3:1] == {$past(vec_chan_a), $past(vec_cond)} && vector_out[7:4] == $past(vec_q[7:4]))
    else $error("modified vector wrong");
  rx_irq_off_a: assert property (iwc_q[0][SCR_IWC_RXMODE_LSB +: 2] == SCR_RXI_OFF |=> !rx_irq[0])
    else $error("receive interrupt while disabled");
  rx_irq_all_a: assert property (iwc_q[0][SCR_IWC_RXMODE_LSB +: 2] == SCR_RXI_ALL && accept[0] |=> rx_irq[0])
    else $error("receive interrupt missing");
  sync_drop_a: assert property (rx_is_sync[0] && rxc_q[0][SCR_RXC_SYNC_INH]
    && frm_q[0][SCR_FRM_STOP_LSB +: 2] == SCR_STOP_SYNC |=> !rx_store[0])
    else $error("sync character stored");
  crc_only_stored_a: assert property (crc_update[0] |-> rx_store[0])
    else $error("crc update without stored character");
  hunt_clear_a: assert property (sync_found[1] && !wr_ch[1] |=> !hunt[1])
    else $error("hunt not cleared on sync");
  ptr_return_a: assert property (wr_ch[0] && ptr_q[0] != SCR_PTR_CMD |=> ptr_q[0] == SCR_PTR_CMD)
    else $error("pointer did not return");
  auto_cts_a: assert property (rxc_q[0][SCR_RXC_AUTO] && cts_s_q[0] |-> !tx_enable[0])
    else $error("transmitter enabled without clear-to-send");
  wr_disabled_a: assert property (!iwc_q[0][SCR_IWC_WR_EN] |-> wait_ready_oe[0] == iwc_q[0][SCR_IWC_WR_READY]
    && wait_ready_o[0] == iwc_q[0][SCR_IWC_WR_READY])
    else $error("disabled wait/ready pin wrong");
  wr_ready_rx_a: assert property (iwc_q[0][7:5] == 3'h7 |-> wait_ready_oe[0] && wait_ready_o[0] == !rx_full[0])
    else $error("ready on receive wrong");

  store_c: cover property (accept[0] ##1 rx_store[0] && rx_irq[0]);
  vec_c: cover property (iwc_q[SCR_CH_B][SCR_IWC_SAV] ##1 vector_out[3]);
  hunt_c: cover property (hunt[0] ##1 !hunt[0]);
endmodule : scr_channel_config

// *** rtl/scr_pkg.sv ***
/*
  Constants for the per-channel serial configuration block: register pointer
  codes, field positions, field encodings and reset values.
  Assumes a byte-wide host write port and two channels, index 0 = A, 1 = B.
*/
package scr_pkg;
  localparam int SCR_CHANNELS = 2;
  localparam int SCR_CH_A = 0;
  localparam int SCR_CH_B = 1;

  // register pointer values
  localparam logic [2:0] SCR_PTR_CMD = 3'h0;
  localparam logic [2:0] SCR_PTR_IWC = 3'h1;
  localparam logic [2:0] SCR_PTR_VEC = 3'h2;
  localparam logic [2:0] SCR_PTR_RXC = 3'h3;
  localparam logic [2:0] SCR_PTR_FRM = 3'h4;
  localparam logic [2:0] SCR_PTR_STA = 3'h6;

  // command field of the command/pointer register
  localparam int SCR_CMD_LSB = 3;
  localparam logic [2:0] SCR_CMD_CHAN_RESET = 3'h3;
  localparam logic [2:0] SCR_CMD_RX_REARM = 3'h4;

  // interrupt/wait control fields
  localparam int SCR_IWC_TX_IE = 1;
  localparam int SCR_IWC_SAV = 2;
  localparam int SCR_IWC_RXMODE_LSB = 3;
  localparam int SCR_IWC_WR_RX = 5;
  localparam int SCR_IWC_WR_READY = 6;
  localparam int SCR_IWC_WR_EN = 7;

  // receiver control fields
  localparam int SCR_RXC_EN = 0;
  localparam int SCR_RXC_SYNC_INH = 1;
  localparam int SCR_RXC_ADDR_SRCH = 2;
  localparam int SCR_RXC_CRC_EN = 3;
  localparam int SCR_RXC_HUNT = 4;
  localparam int SCR_RXC_AUTO = 5;
  localparam int SCR_RXC_LEN_LSB = 6;

  // framing/mode fields
  localparam int SCR_FRM_PAR_EN = 0;
  localparam int SCR_FRM_PAR_EVEN = 1;
  localparam int SCR_FRM_STOP_LSB = 2;
  localparam int SCR_FRM_SYNC_LSB = 4;

  // vector bits replaced when status-affects-vector is set
  localparam int SCR_VEC_COND_LSB = 1;
  localparam int SCR_VEC_CHAN = 3;

  localparam logic [7:0] SCR_GLOBAL_ADDR = 8'hFF;
  localparam logic [7:0] SCR_SDLC_FLAG = 8'h7E;
  localparam logic [7:0] SCR_REG_RESET = 8'h00;

  typedef enum logic [1:0] {SCR_RXI_OFF, SCR_RXI_FIRST, SCR_RXI_ALL, SCR_RXI_ALL_NOPAR} scr_rxi_e;
  typedef enum logic [1:0] {SCR_STOP_SYNC, SCR_STOP_1, SCR_STOP_1P5, SCR_STOP_2} scr_stop_e;
  typedef enum logic [1:0] {SCR_SYNC_8, SCR_SYNC_16, SCR_SYNC_SDLC, SCR_SYNC_EXT} scr_sync_e;
  typedef enum logic [1:0] {SCR_COND_TXE, SCR_COND_EXT, SCR_COND_RXC, SCR_COND_SPEC} scr_cond_e;
endpackage : scr_pkg

// *** rtl/scr_wait_ready.sv ***
/*
  Wait/ready pin driver for one channel.
  Assumes buffer states come from logic on the same clock; the pin is
  resolved outside from the output and its enable.
*/
`timescale 1ns/1ns
module scr_wait_ready (
  input wire logic enable,   // wait/ready function enabled
  input wire logic ready_sel, // 1 ready function, 0 wait function
  input wire logic follow_rx, // 1 follow receive buffer, 0 transmit
  input wire logic tx_full,  // transmit buffer full
  input wire logic rx_full,  // receive buffer full
  input wire logic port_sel, // data port being accessed
  output logic pin_o,        // pin level when driven
  output logic pin_oe        // pin driven
);
  always_comb begin
    pin_o = 1'b0;
    pin_oe = 1'b0;
    if (!enable) begin
      pin_o = ready_sel;
      pin_oe = ready_sel;
    end else if (ready_sel) begin
      pin_oe = 1'b1;
      pin_o = follow_rx ? !rx_full : tx_full;
    end else begin
      pin_oe = port_sel & (follow_rx ? !rx_full : tx_full);
    end
  end
endmodule : scr_wait_ready

// *** sim/scr_host_model.sv ***
/*
  Host side model: writes configuration bytes as a pointer byte to the
  command register followed by the data byte.
  Assumes the host bus is synchronous to core_clk.
*/
`timescale 1ns/1ns
module scr_host_model (
  input wire logic core_clk,   // system clock
  output logic host_wr,        // byte write strobe
  output logic host_chan,      // 0 channel A, 1 channel B
  output logic [7:0] host_data // write byte
);
  initial begin
    host_wr = 1'b0;
    host_chan = 1'b0;
    host_data = 8'h00;
  end

  // the bus is released with inverted data so a stale byte is never mistaken for a write
  task automatic wr_reg(input logic chan, input logic [2:0] ptr, input logic [7:0] val);
    @(posedge core_clk);
    host_wr <= 1'b1;
    host_chan <= chan;
    host_data <= {5'h00, ptr};
    @(posedge core_clk);
    host_data <= val;
    @(posedge core_clk);
    host_wr <= 1'b0;
    host_data <= ~val;
  endtask : wr_reg
endmodule : scr_host_model

// *** sim/testbench.sv ***
/*
  Self-checking bench for the channel configuration block, channel A mostly.
  Assumes scr_pkg and the host model are compiled first.
*/
`timescale 1ns/1ns
module testbench;
  import scr_pkg::*;
  logic core_clk, reset, host_wr, host_chan, vec_chan_a, seen;
  logic [7:0] host_data, vector_out, char_bits;
  logic [1:0] cts_n, carrier_detect_in, tx_en_req, tx_empty, rx_full, port_sel, rx_char_done, e;
  logic [1:0] rx_is_sync, rx_is_addr, rx_overrun, rx_framing_err, rx_eof, sync_found, tx_irq, rx_irq;
  logic [1:0] rx_store, rx_parity_err, crc_update, hunt, tx_enable, rx_enable, parity_en, parity_even;
  logic [1:0] wait_ready_o, wait_ready_oe;
  logic [17:0] rx_raw;
  logic [15:0] rx_byte;
  logic [3:0] stop_code, sync_mode;
  scr_cond_e vec_cond;
  int n_fail, checks_done, cycles;
  int len_tab[4] = '{5, 7, 6, 8};

  scr_host_model host (.core_clk(core_clk), .host_wr(host_wr), .host_chan(host_chan), .host_data(host_data));
  scr_channel_config DUT (.core_clk(core_clk), .reset(reset), .host_wr(host_wr), .host_chan(host_chan),
    .host_data(host_data), .cts_n(cts_n), .carrier_detect_in(carrier_detect_in), .tx_en_req(tx_en_req),
    .tx_empty(tx_empty), .rx_full(rx_full), .port_sel(port_sel), .rx_char_done(rx_char_done), .rx_raw(rx_raw),
    .rx_is_sync(rx_is_sync), .rx_is_addr(rx_is_addr), .rx_overrun(rx_overrun), .rx_framing_err(rx_framing_err),
    .rx_eof(rx_eof), .sync_found(sync_found), .vec_chan_a(vec_chan_a), .vec_cond(vec_cond),
    .vector_out(vector_out), .tx_irq(tx_irq), .rx_irq(rx_irq), .rx_store(rx_store), .rx_byte(rx_byte),
    .rx_parity_err(rx_parity_err), .crc_update(crc_update), .hunt(hunt), .tx_enable(tx_enable),
    .rx_enable(rx_enable), .char_bits(char_bits), .parity_en(parity_en), .parity_even(parity_even),
    .stop_code(stop_code), .sync_mode(sync_mode), .wait_ready_o(wait_ready_o), .wait_ready_oe(wait_ready_oe));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic rx_char(input logic [8:0] raw, input logic sync, input logic addr);
    @(posedge core_clk);
    rx_raw[8:0] <= raw;
    rx_is_sync <= {1'b0, sync};
    rx_is_addr <= {1'b0, addr};
    rx_char_done <= 2'b01;
    @(posedge core_clk);
    rx_char_done <= 2'b00;
    #1;
  endtask : rx_char

  // returns {driven, level}; level only matters while driven
  function automatic logic [1:0] exp_wr(input logic [2:0] m, input logic txf, rxf, sel);
    if (!m[2]) return m[1] ? 2'b11 : 2'b00;
    if (m[1]) return {1'b1, m[0] ? ~rxf : txf};
    return ((m[0] ? ~rxf : txf) && sel) ? 2'b10 : 2'b00;
  endfunction : exp_wr

  initial begin
    reset = 1'b1;
    {cts_n, carrier_detect_in, rx_full, port_sel, rx_char_done, rx_is_sync, rx_is_addr} = '0;
    {rx_overrun, rx_framing_err, rx_eof, sync_found, rx_raw, vec_chan_a} = '0;
    tx_en_req = 2'b11;
    tx_empty = 2'b11;
    vec_cond = SCR_COND_TXE;
    n_fail = 0;
    checks_done = 0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    tick(1);
    chk({hunt, rx_enable, wait_ready_oe, 2'b00}, 8'hC0);
    chk(vector_out, 8'h00);
    $display("reset state done");
    for (int k = 0; k < 4; k++) begin
      host.wr_reg(1'b0, SCR_PTR_FRM, {2'b00, k[1:0], k[1:0], k[0], 1'b1});
      tick(1);
      chk({stop_code[1:0], sync_mode[1:0], 2'b00, parity_even[0], parity_en[0]}, {k[1:0], k[1:0], 2'b00, k[0], 1'b1});
      host.wr_reg(1'b0, SCR_PTR_RXC, {k[1:0], 6'h00});
      tick(1);
      chk({4'h0, char_bits[3:0]}, 8'(len_tab[k]));
    end
    $display("framing and length done");
    for (int m = 0; m < 8; m++) begin
      host.wr_reg(1'b0, SCR_PTR_IWC, {m[2:0], 5'h00});
      for (int i = 0; i < 8; i++) begin
        @(posedge core_clk);
        tx_empty <= {2{~i[0]}};
        rx_full <= {2{i[1]}};
        port_sel <= {2{i[2]}};
        tick(1);
        e = exp_wr(m[2:0], i[0], i[1], i[2]);
        chk({6'h00, wait_ready_oe[0], wait_ready_oe[0] & wait_ready_o[0]}, {6'h00, e[1], e[1] & e[0]});
      end
    end
    $display("wait ready done");
    host.wr_reg(1'b1, SCR_PTR_VEC, 8'hA5);
    host.wr_reg(1'b0, SCR_PTR_VEC, 8'h3C);
    tick(2);
    chk(vector_out, 8'hA5);
    host.wr_reg(1'b1, SCR_PTR_IWC, 8'h04);
    for (int k = 0; k < 8; k++) begin
      @(posedge core_clk);
      vec_chan_a <= k[2];
      vec_cond <= scr_cond_e'(k[1:0]);
      tick(2);
      chk(vector_out, {4'hA, k[2], k[1:0], 1'b1});
    end
    $display("vector done");
    host.wr_reg(1'b0, SCR_PTR_FRM, 8'h04);
    host.wr_reg(1'b0, SCR_PTR_IWC, 8'h12);
    host.wr_reg(1'b0, SCR_PTR_RXC, 8'hC9);
    rx_char(9'h05A, 1'b0, 1'b0);
    chk({rx_store[0], rx_irq[0], crc_update[0], 5'h00}, 8'hE0);
    chk(rx_byte[7:0], 8'h5A);
    host.wr_reg(1'b0, SCR_PTR_FRM, 8'h05);
    host.wr_reg(1'b0, SCR_PTR_RXC, 8'h49);
    rx_char(9'h0C5, 1'b0, 1'b0);
    chk(rx_byte[7:0], 8'hC5);
    chk({7'h00, rx_parity_err[0]}, 8'h01);
    host.wr_reg(1'b0, SCR_PTR_FRM, 8'h00);
    host.wr_reg(1'b0, SCR_PTR_RXC, 8'hCB);
    rx_char(9'h016, 1'b1, 1'b0);
    chk({7'h00, rx_store[0]}, 8'h00);
    host.wr_reg(1'b0, SCR_PTR_STA, 8'h42);
    host.wr_reg(1'b0, SCR_PTR_FRM, 8'h20);
    host.wr_reg(1'b0, SCR_PTR_IWC, 8'h0A);
    // second byte lands on the command register: re-arm first-character interrupt
    host.wr_reg(1'b0, SCR_PTR_CMD, 8'h20);
    host.wr_reg(1'b0, SCR_PTR_RXC, 8'hC5);
    rx_char(9'h037, 1'b0, 1'b1);
    chk({6'h00, rx_store[0], rx_irq[0]}, 8'h00);
    rx_char(9'h011, 1'b0, 1'b0);
    chk({6'h00, rx_store[0], rx_irq[0]}, 8'h00);
    rx_char(9'h042, 1'b0, 1'b1);
    chk({6'h00, rx_store[0], rx_irq[0]}, 8'h03);
    rx_char(9'h0FF, 1'b0, 1'b1);
    chk({6'h00, rx_store[0], rx_irq[0]}, 8'h02);
    $display("receive done");
    @(posedge core_clk);
    tx_empty <= 2'b00;
    tick(2);
    @(posedge core_clk);
    tx_empty <= 2'b11;
    seen = 1'b0;
    repeat (3) begin
      tick(1);
      seen = seen | tx_irq[0];
    end
    chk({7'h00, seen}, 8'h01);
    @(posedge core_clk);
    sync_found <= 2'b11;
    @(posedge core_clk);
    sync_found <= 2'b00;
    tick(1);
    chk({7'h00, hunt[0]}, 8'h00);
    host.wr_reg(1'b0, SCR_PTR_RXC, 8'hD9);
    tick(1);
    chk({7'h00, hunt[0]}, 8'h01);
    host.wr_reg(1'b0, SCR_PTR_RXC, 8'hE1);
    @(posedge core_clk);
    carrier_detect_in <= 2'b11;
    cts_n <= 2'b11;
    tick(4);
    chk({6'h00, tx_enable[0], rx_enable[0]}, 8'h00);
    @(posedge core_clk);
    carrier_detect_in <= 2'b00;
    cts_n <= 2'b00;
    tick(4);
    chk({6'h00, tx_enable[0], rx_enable[0]}, 8'h03);
    $display("interrupt hunt auto done");
    end_sim();
  end
endmodule : testbench
